// [rtl/tct_pkg.sv]
// Package for the translation cache tagging block: widths, field layouts,
// cache geometry, page and walk encodings, entry structs.
// Assumes one clock domain and fill/lookup/invalidate requests from the walker.
//
// Contract
// R1 - Caching-mode capability output reports whether faulted entries get cached
// R2 - With caching mode clear, faulted or not-present entries never fill
// R3 - Software invalidates after structure updates when caching mode set
// R4 - Context cache holds context entries, looked up by source id
// R5 - PASID cache holds PASID-table entries, looked up by PASID and source
// R6 - Translation buffer holds final translations of any walk type
// R7 - Paging-structure caches hold intermediate entries from all walks
// R8 - Lookup hits only when every tag of the cache matches
// R9 - Invalidation selects entries matching the relevant tag subset
// R10 - Request without PASID hits only no-PASID entries, source and page
// R11 - Request with PASID compares source, PASID and page
// R12 - First-level/nested tags are address top index down to 12/21/30
// R13 - Second-level tags are address guest width down to 12/21/30
// R14 - First-level top index is 56 for five-level, 47 for four-level (the first-level paging cache uses 56 in both)
// R15 - Paging-structure tags from top index down to 48/39/30/21
// R16 - No-PASID requests look up PASID and paging caches with default PASID
// R17 - No-PASID fills tagged with default PASID, still marked no-PASID
// R18 - Optional: PASID requests may hit same-source no-PASID entries
// R19 - Interrupt cache entries tagged with interrupt index
// R20 - Buffer lookup masks address bits below the entry page size
package tct_pkg;

    localparam int SID_W    = 16;
    localparam int PASID_W  = 20;
    localparam int DID_W    = 16;
    localparam int ADDR_W   = 64;
    localparam int DATA_W   = 64;
    localparam int IIDX_W   = 16;
    localparam int ENTRIES  = 8;
    localparam int IDX_W    = 3;

    // Address bit boundaries
    localparam int TOP_5LVL  = 56;
    localparam int TOP_4LVL  = 47;
    localparam int SHIFT_4K  = 12;
    localparam int SHIFT_2M  = 21;
    localparam int SHIFT_1G  = 30;
    localparam int SHIFT_L4  = 39;
    localparam int SHIFT_L5  = 48;
    localparam logic [5:0] MAX_GUEST_ADDR_WIDTH_RST = 6'h2f;  // Guest width top index

    // Caches addressed by the request
    typedef enum logic [2:0] {
        TCT_CC  = 3'h0,   // Context cache
        TCT_PC  = 3'h1,   // PASID cache
        TCT_TB  = 3'h2,   // Translation buffer
        TCT_FLP = 3'h3,   // First-level paging-structure cache
        TCT_SLP = 3'h4,   // Second-level paging-structure cache
        TCT_IRC = 3'h5    // Interrupt remapping cache
    } tct_cache_e;

    // Page size or paging-structure level
    typedef enum logic [1:0] {
        TCT_PG_4K  = 2'h0,   // also PDE level for paging caches
        TCT_PG_2M  = 2'h1,   // PDPE level
        TCT_PG_1G  = 2'h2,   // PML4E level
        TCT_PG_512 = 2'h3    // PML5E level
    } tct_size_e;

    // Walk type that produced a buffer entry
    typedef enum logic [1:0] {
        TCT_WK_FL   = 2'h0,
        TCT_WK_SL   = 2'h1,
        TCT_WK_NEST = 2'h2,
        TCT_WK_PT   = 2'h3
    } tct_walk_e;

    // Invalidation granularity, one bit per tag that must match
    typedef struct packed {
        logic use_sid;
        logic use_did;
        logic use_pasid;
        logic use_addr;
        logic use_ptt;
    } tct_isel_s;

    // One request from the walker or the invalidation engine
    typedef struct packed {
        tct_cache_e             cache;
        logic                   has_pasid;
        logic                   scalable;
        logic [SID_W-1:0]       sid;
        logic [PASID_W-1:0]     pasid;
        logic [PASID_W-1:0]     default_pasid_field;
        logic [DID_W-1:0]       did;
        logic [ADDR_W-1:0]      addr;
        logic [IIDX_W-1:0]      iidx;
        tct_size_e              size;
        tct_walk_e              walk;
        logic [2:0]             pasid_translation_type;
        logic                   faulted;
        logic [DATA_W-1:0]      data;
    } tct_req_s;

    // One cached entry, all tag fields present, unused ones still loaded from the request
    typedef struct packed {
        logic                   valid;
        logic                   no_pasid;
        logic [SID_W-1:0]       sid;
        logic [PASID_W-1:0]     pasid;
        logic [DID_W-1:0]       did;
        logic [ADDR_W-1:0]      tag;
        tct_size_e              size;
        logic [2:0]             ptt;
        logic [DATA_W-1:0]      data;
    } tct_ent_s;

    // Lookup answer
    typedef struct packed {
        logic                   hit;
        logic                   miss;
        logic [DATA_W-1:0]      data;
    } tct_rsp_s;

endpackage : tct_pkg

// [rtl/tct_addr_tag.sv]
// Address tag former: keeps bits from the top index down to the size shift.
// Assumes combinational use; top index and size come from the caller.
`timescale 1ns/1ps
module tct_addr_tag
    import tct_pkg::*;
(
    // Address in
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [5:0]        top_i,
    input  wire tct_size_e         size_i,
    input  wire logic              pstruct_i,
    // Masked tag out
    output logic      [ADDR_W-1:0] tag_o
);
    logic [5:0] low;

    // Size picks the lowest kept bit
    always_comb
    begin
        case (size_i)
            TCT_PG_4K:  low = pstruct_i ? 6'(SHIFT_2M) : 6'(SHIFT_4K); // R12 R13 R15
            TCT_PG_2M:  low = pstruct_i ? 6'(SHIFT_1G) : 6'(SHIFT_2M); // R12 R13 R15
            TCT_PG_1G:  low = pstruct_i ? 6'(SHIFT_L4) : 6'(SHIFT_1G); // R12 R13 R15
            TCT_PG_512: low = 6'(SHIFT_L5);                          // R15
            default:    low = 6'(SHIFT_4K);
        endcase
        // Keep bits top..low only
        for (int b = 0; b < ADDR_W; b++)
        begin
            tag_o[b] = addr_i[b] && (b >= int'(low)) && (b <= int'(top_i));
        end
    end
endmodule : tct_addr_tag

// [rtl/tct_tag_store.sv]
// One tagged cache array with fill, lookup and tag-subset invalidation.
// Assumes tags are pre-formed by the caller; round-robin replacement.
`timescale 1ns/1ps
module tct_tag_store
    import tct_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Which tags take part in a lookup
    input  wire tct_isel_s   lk_sel_i,
    input  wire logic        tb_mode_i,
    input  wire logic        share_i,
    // Fill
    input  wire logic        fill_i,
    input  wire tct_ent_s    fill_ent_i,
    // Lookup
    input  wire logic        look_i,
    input  wire tct_ent_s    look_ent_i,
    // Invalidate
    input  wire logic        inv_i,
    input  wire tct_isel_s   inv_sel_i,
    input  wire tct_ent_s    inv_ent_i,
    // Result, combinational
    output logic             hit_o,
    output logic [DATA_W-1:0] data_o
);
    typedef struct packed {
        tct_ent_s [ENTRIES-1:0] ent;
        logic [IDX_W-1:0]       ptr;
    } tct_st_s;

    tct_st_s st_r;
    tct_st_s st_nxt;
    logic [ADDR_W-1:0] pmask;
    logic              m;
    logic              pk;

    // Hit search and next state
    always_comb
    begin
        st_nxt = st_r;
        hit_o  = 1'b0;
        data_o = '0;
        pmask  = '0;
        m      = 1'b0;
        pk     = 1'b0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            // Page-size mask from the stored entry, not the request
            case (st_r.ent[i].size)
                TCT_PG_2M: pmask = ~((ADDR_W'(1) << SHIFT_2M) - 1'b1); // R20
                TCT_PG_1G: pmask = ~((ADDR_W'(1) << SHIFT_1G) - 1'b1); // R20
                default:   pmask = ~((ADDR_W'(1) << SHIFT_4K) - 1'b1);
            endcase
            if (!tb_mode_i)
                pmask = '1;
            // Buffer: PASID kind must agree unless sharing allowed
            if (look_ent_i.no_pasid)
                pk = st_r.ent[i].no_pasid;                         // R10
            else
                pk = !st_r.ent[i].no_pasid
                     || (share_i && st_r.ent[i].sid == look_ent_i.sid); // R11 R18
            m = st_r.ent[i].valid
                && (!lk_sel_i.use_sid || st_r.ent[i].sid == look_ent_i.sid)
                && (!lk_sel_i.use_did || st_r.ent[i].did == look_ent_i.did)
                // Only the buffer skips PASID; other caches use default PASID
                && (!lk_sel_i.use_pasid
                    || (tb_mode_i && look_ent_i.no_pasid)          // R16
                    || (tb_mode_i && st_r.ent[i].no_pasid && share_i)
                    || st_r.ent[i].pasid == look_ent_i.pasid)
                && (!lk_sel_i.use_addr || ((st_r.ent[i].tag & pmask)
                    == (look_ent_i.tag & pmask)))
                && (!tb_mode_i || pk);                             // R8
            if (look_i && m && !hit_o)
            begin
                hit_o  = 1'b1;
                data_o = st_r.ent[i].data;
            end
            // Every selected tag must match to drop an entry
            if (inv_i && st_r.ent[i].valid
                && (!inv_sel_i.use_sid || st_r.ent[i].sid == inv_ent_i.sid)
                && (!inv_sel_i.use_did || st_r.ent[i].did == inv_ent_i.did)
                && (!inv_sel_i.use_pasid
                    || st_r.ent[i].pasid == inv_ent_i.pasid)
                && (!inv_sel_i.use_ptt || st_r.ent[i].ptt == inv_ent_i.ptt)
                && (!inv_sel_i.use_addr
                    || (st_r.ent[i].tag & pmask) == (inv_ent_i.tag & pmask)))
                st_nxt.ent[i].valid = 1'b0;                        // R9
        end
        // Fill after invalidate so a same-cycle fill survives
        if (fill_i)
        begin
            st_nxt.ent[st_r.ptr] = fill_ent_i;
            st_nxt.ptr           = st_r.ptr + 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule : tct_tag_store

// [rtl/tct_top.sv]
// Translation cache tagging: six tagged caches with tag forming per cache.
// Assumes the walker presents one request per cycle, inputs synchronous.
`timescale 1ns/1ps
module tct_top
    import tct_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Configuration
    input  wire logic        five_level_i,
    input  wire logic [5:0]  max_guest_addr_width_i,
    input  wire logic        share_nopasid_i,
    // Walker requests
    input  wire logic        look_i,
    input  wire logic        fill_i,
    input  wire tct_req_s    req_i,
    // Invalidation requests
    input  wire logic        inv_i,
    input  wire tct_isel_s   inv_sel_i,
    input  wire tct_req_s    inv_req_i,
    // Answers
    output tct_rsp_s         rsp_o,
    output logic             caching_mode_flag_o
);
    localparam int NC = 6;

    typedef struct packed {
        tct_rsp_s rsp;
        logic     cm;
    } tct_top_s;

    tct_top_s st_r;
    tct_top_s st_nxt;

    tct_ent_s  look_ent;
    tct_ent_s  fill_ent;
    tct_ent_s  inv_ent;
    logic [5:0] top_q;
    logic [5:0] top_i;
    logic       ps_q;
    logic       ps_i;
    logic [ADDR_W-1:0] tag_q;
    logic [ADDR_W-1:0] tag_inv;
    logic [NC-1:0] fill_v;
    logic [NC-1:0] look_v;
    logic [NC-1:0] inv_v;
    logic [NC-1:0] hit_v;
    logic [DATA_W-1:0] data_v [NC];
    tct_isel_s sel_v [NC];
    logic [PASID_W-1:0] eff_pasid;

    // Top index: buffer uses paging depth, first-level paging cache bit 56, second-level guest width
    always_comb
    begin
        ps_q  = (req_i.cache == TCT_FLP) || (req_i.cache == TCT_SLP);
        ps_i  = (inv_req_i.cache == TCT_FLP) || (inv_req_i.cache == TCT_SLP);
        top_q = five_level_i ? 6'(TOP_5LVL) : 6'(TOP_4LVL);      // R14
        if (req_i.cache == TCT_FLP)
            top_q = 6'(TOP_5LVL);                                 // R15
        else if (req_i.cache == TCT_SLP
                 || (req_i.cache == TCT_TB && req_i.walk == TCT_WK_SL))
            top_q = max_guest_addr_width_i;                       // R13 R15
        top_i = five_level_i ? 6'(TOP_5LVL) : 6'(TOP_4LVL);
        if (inv_req_i.cache == TCT_FLP)
            top_i = 6'(TOP_5LVL);
        else if (inv_req_i.cache == TCT_SLP
                 || (inv_req_i.cache == TCT_TB
                     && inv_req_i.walk == TCT_WK_SL))
            top_i = max_guest_addr_width_i;
    end

    // Address tags for the request and for the invalidation
    tct_addr_tag u_tag_req (
        .addr_i    (req_i.addr),
        .top_i     (top_q),
        .size_i    (req_i.size),
        .pstruct_i (ps_q),
        .tag_o     (tag_q)
    );

    tct_addr_tag u_tag_inv (
        .addr_i    (inv_req_i.addr),
        .top_i     (top_i),
        .size_i    (inv_req_i.size),
        .pstruct_i (ps_i),
        .tag_o     (tag_inv)
    );

    // Entry images for fill, lookup and invalidation
    always_comb
    begin
        // No-PASID scalable requests stand in with the default PASID
        eff_pasid = (req_i.scalable && !req_i.has_pasid)
                    ? req_i.default_pasid_field : req_i.pasid; // R16 R17
        look_ent          = '0;
        look_ent.valid    = 1'b1;
        look_ent.no_pasid = !req_i.has_pasid;
        look_ent.sid      = req_i.sid;
        look_ent.pasid    = eff_pasid;
        look_ent.did      = req_i.did;
        look_ent.tag      = (req_i.cache == TCT_IRC)
                            ? ADDR_W'(req_i.iidx) : tag_q;        // R19
        look_ent.size     = req_i.size;
        look_ent.ptt      = req_i.pasid_translation_type;
        fill_ent          = look_ent;
        fill_ent.data     = req_i.data;
        inv_ent           = '0;
        inv_ent.sid       = inv_req_i.sid;
        inv_ent.pasid     = inv_req_i.pasid;
        inv_ent.did       = inv_req_i.did;
        inv_ent.tag       = (inv_req_i.cache == TCT_IRC)
                            ? ADDR_W'(inv_req_i.iidx) : tag_inv;
        inv_ent.ptt       = inv_req_i.pasid_translation_type;
    end

    // Lookup tag sets per cache
    always_comb
    begin
        sel_v[TCT_CC]  = '{use_sid:1'b1, default:1'b0};           // R4
        sel_v[TCT_PC]  = '{use_sid:1'b1, use_pasid:1'b1,
                           default:1'b0};                          // R5
        sel_v[TCT_TB]  = '{use_sid:1'b1, use_pasid:1'b1,
                           use_addr:1'b1, default:1'b0};           // R6
        sel_v[TCT_FLP] = '{use_did:1'b1, use_pasid:1'b1,
                           use_addr:1'b1, default:1'b0};           // R7
        sel_v[TCT_SLP] = '{use_did:1'b1, use_addr:1'b1,
                           default:1'b0};                          // R7
        sel_v[TCT_IRC] = '{use_addr:1'b1, default:1'b0};          // R19
    end

    // Steering; faulted entries are never kept in this hardware mode
    always_comb
    begin
        for (int c = 0; c < NC; c++)
        begin
            look_v[c] = look_i && (req_i.cache == tct_cache_e'(c));
            fill_v[c] = fill_i && !req_i.faulted
                        && (req_i.cache == tct_cache_e'(c));      // R2
            inv_v[c]  = inv_i && (inv_req_i.cache == tct_cache_e'(c));
        end
    end

    // One store per cache
    generate
        for (genvar g = 0; g < NC; g++)
        begin : g_store
            tct_tag_store u_store (
                .mclk_i     (mclk_i),
                .resetn_i   (resetn_i),
                .lk_sel_i   (sel_v[g]),
                .tb_mode_i  (g == TCT_TB),
                .share_i    (share_nopasid_i),
                .fill_i     (fill_v[g]),
                .fill_ent_i (fill_ent),
                .look_i     (look_v[g]),
                .look_ent_i (look_ent),
                .inv_i      (inv_v[g]),
                .inv_sel_i  (inv_sel_i),
                .inv_ent_i  (inv_ent),
                .hit_o      (hit_v[g]),
                .data_o     (data_v[g])
            );
        end
    endgenerate

    // Registered answer, one cycle after the lookup
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.cm       = 1'b0;                                   // R1
        st_nxt.rsp.hit  = |hit_v;                                 // R8
        st_nxt.rsp.miss = look_i && !(|hit_v);
        st_nxt.rsp.data = '0;
        for (int c = 0; c < NC; c++)
        begin
            if (hit_v[c])
                st_nxt.rsp.data = data_v[c];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rsp_o               = st_r.rsp;
    assign caching_mode_flag_o = st_r.cm;
endmodule : tct_top

// [tb/tct_top_asserts.sv]
// Checker for the translation cache tagging top: answers and tag hits.
// Assumes it is bound to tct_top and sees only that module's ports.
`timescale 1ns/1ps
module tct_top_asserts
    import tct_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk_i,
    input  wire logic      resetn_i,
    // Requests
    input  wire logic      look_i,
    input  wire logic      fill_i,
    input  wire tct_req_s  req_i,
    input  wire logic      inv_i,
    input  wire tct_isel_s inv_sel_i,
    input  wire tct_req_s  inv_req_i,
    // Answers
    input  wire tct_rsp_s  rsp_o,
    input  wire logic      caching_mode_flag_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    // Set by the first good fill; until then every lookup must miss
    logic any_fill_r;
    logic any_fill_nxt;
    always_comb any_fill_nxt = any_fill_r | (fill_i & ~req_i.faulted);
    always_ff @(posedge mclk_i or negedge resetn_i)
        if (!resetn_i)
            any_fill_r <= 1'b0;
        else
            any_fill_r <= any_fill_nxt;

    // Good fill followed at once by a lookup of the same request
    sequence good_fill_s;
        fill_i && !req_i.faulted && !inv_i;
    endsequence
    sequence same_look_s;
        look_i && !inv_i && req_i == $past(req_i);
    endsequence

    cm_flag_clear_a: assert property (caching_mode_flag_o == 1'b0)
        else $error("caching mode flag not clear");
    no_early_hit_a: assert property (look_i && !any_fill_r |=>
        rsp_o.miss && !rsp_o.hit) else $error("hit with nothing filled");
    one_answer_a: assert property (look_i |=> rsp_o.hit != rsp_o.miss)
        else $error("lookup gave no single answer");
    quiet_idle_a: assert property (!look_i |=> !rsp_o.hit && !rsp_o.miss)
        else $error("answer without a lookup");
    exclusive_a: assert property (!(rsp_o.hit && rsp_o.miss))
        else $error("hit and miss together");
    fill_hit_a: assert property (good_fill_s ##1 same_look_s |=>
        rsp_o.hit && rsp_o.data == $past(req_i.data, 2))
        else $error("filled entry not returned");
    irq_index_hit_a: assert property ((good_fill_s and req_i.cache == TCT_IRC)
        ##1 look_i && !inv_i && req_i.cache == TCT_IRC
        && req_i.iidx == $past(req_i.iidx) |=> rsp_o.hit)
        else $error("interrupt index did not hit");
    inv_sid_miss_a: assert property (inv_i && !fill_i
        && inv_req_i.cache == TCT_CC && inv_sel_i == tct_isel_s'(5'h10)
        ##1 look_i && req_i.cache == TCT_CC
        && req_i.sid == $past(inv_req_i.sid) |=> rsp_o.miss)
        else $error("invalidated context entry still hit");
endmodule : tct_top_asserts

bind tct_top tct_top_asserts u_asserts (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .look_i(look_i), .fill_i(fill_i),
    .req_i(req_i), .inv_i(inv_i), .inv_sel_i(inv_sel_i),
    .inv_req_i(inv_req_i), .rsp_o(rsp_o),
    .caching_mode_flag_o(caching_mode_flag_o)
);

// [tb/tct_host_model.sv]
// Walker and invalidating software model issuing cache requests.
// Assumes the bench calls its tasks; each strobe lasts one cycle.
`timescale 1ns/1ps
module tct_host_model
    import tct_pkg::*;
(
    // Clock
    input  wire logic mclk_i,
    // Requests toward the caches
    output logic      look_o,
    output logic      fill_o,
    output tct_req_s  req_o,
    output logic      inv_o,
    output tct_isel_s inv_sel_o,
    output tct_req_s  inv_req_o
);
    // Quiet lines before the first request
    initial
    begin
        look_o = 1'b0;
        fill_o = 1'b0;
        inv_o = 1'b0;
        req_o = '0;
        inv_sel_o = '0;
        inv_req_o = '0;
    end

    // Strobes bits {inv, fill, look}; held until the next call
    task automatic issue(input logic [2:0] k, input tct_req_s r,
                         input tct_isel_s s);
        @(posedge mclk_i);
        look_o <= k[0];
        fill_o <= k[1];
        inv_o <= k[2];
        req_o <= r;
        inv_req_o <= r;
        inv_sel_o <= s;
    endtask : issue

    // Released fields flip so a stale tag cannot match by luck
    task automatic idle();
        @(posedge mclk_i);
        look_o <= 1'b0;
        fill_o <= 1'b0;
        inv_o <= 1'b0;
        req_o <= tct_req_s'(~req_o);
        inv_req_o <= tct_req_s'(~inv_req_o);
    endtask : idle
endmodule : tct_host_model

// [tb/testbench.sv]
// Self-checking bench for tct_top: fills, lookups and invalidations.
// Assumes the host model issues requests; answers come one cycle later.
`timescale 1ns/1ps
module testbench;
    import tct_pkg::*;

    logic       mclk_i, resetn_i, five_level_i, share_nopasid_i;
    logic [5:0] max_guest_addr_width_i;
    logic       look_i, fill_i, inv_i, caching_mode_flag_o;
    tct_req_s   req_i, inv_req_i, r, q;
    tct_isel_s  inv_sel_i;
    tct_rsp_s   rsp_o;
    int         num_errors, comparisons, seed, lo, hi;

    tct_top DUT (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .five_level_i(five_level_i),
        .max_guest_addr_width_i(max_guest_addr_width_i),
        .share_nopasid_i(share_nopasid_i), .look_i(look_i), .fill_i(fill_i),
        .req_i(req_i), .inv_i(inv_i), .inv_sel_i(inv_sel_i),
        .inv_req_i(inv_req_i), .rsp_o(rsp_o),
        .caching_mode_flag_o(caching_mode_flag_o));
    tct_host_model u_host (
        .mclk_i(mclk_i), .look_o(look_i), .fill_o(fill_i), .req_o(req_i),
        .inv_o(inv_i), .inv_sel_o(inv_sel_i), .inv_req_o(inv_req_i));

    // 40 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Lowest tagged address bit: buffer pages or paging-cache levels
    function automatic int low_bit(input tct_size_e s, input logic ps);
        return (ps ? 21 : 12) + 9 * int'(s);
    endfunction : low_bit

    // Highest tagged bit of a buffer entry for its walk type
    function automatic int top_bit(input tct_walk_e w);
        if (w == TCT_WK_SL)
            return int'(max_guest_addr_width_i);
        return five_level_i ? 56 : 47;
    endfunction : top_bit

    // Random legacy request, clean flags, for cache c
    function automatic tct_req_s rnd(input tct_cache_e c);
        logic [255:0] v;
        tct_req_s     t;
        for (int i = 0; i < 8; i++)
            v = {v[223:0], $random(seed)};
        t = v[$bits(tct_req_s)-1:0];
        t.cache = c;
        t.has_pasid = 1'b0;
        t.scalable = 1'b0;
        t.faulted = 1'b0;
        return t;
    endfunction : rnd

    // Optional fill, then lookup; answer is read one cycle on
    task automatic look(input tct_req_s x, input logic fl, input logic hit);
        if (fl)
            u_host.issue(3'h2, x, '0);
        u_host.issue(3'h1, x, '0);
        u_host.idle();
        #1;
        check("hit", 64'(rsp_o.hit), 64'(hit));
        check("miss", 64'(rsp_o.miss), 64'(!hit));
        if (hit)
            check("data", rsp_o.data, x.data);
    endtask : look

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        seed = 32'h6906;
        num_errors = 0;
        comparisons = 0;
        resetn_i = 1'b0;
        five_level_i = 1'b0;
        share_nopasid_i = 1'b0;
        max_guest_addr_width_i = 6'h2a;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        #1;
        check("cm flag", 64'(caching_mode_flag_o), 64'h0);
        check("rsp idle", 64'(rsp_o.hit | rsp_o.miss), 64'h0);
        // Faulted fills never land, in any cache
        for (int c = 0; c < 6; c++)
        begin
            r = rnd(tct_cache_e'(c));
            r.faulted = 1'b1;
            u_host.issue(3'h2, r, '0);
            look(r, 0, 0);
        end
        // Buffer page tags over walk, size and paging depth
        for (int i = 0; i < 18; i++)
        begin
            five_level_i <= i[0];
            #1;
            r = rnd(TCT_TB);
            r.walk = tct_walk_e'(i % 3);
            r.size = tct_size_e'(i / 6);
            lo = low_bit(r.size, 1'b0);
            hi = top_bit(r.walk);
            look(r, 1, 1);
            q = r;
            q.addr = r.addr ^ ((64'h1 << lo) - 64'h1);
            look(q, 0, 1);
            q.addr[hi+1] = ~q.addr[hi+1];
            look(q, 0, 1);
            q.addr[lo] = ~q.addr[lo];
            look(q, 0, 0);
            q = r;
            q.addr[hi] = ~q.addr[hi];
            look(q, 0, 0);
        end
        // Scalable buffer: no-PASID and PASID entries kept apart
        r = rnd(TCT_TB);
        r.scalable = 1'b1;
        r.size = TCT_PG_4K;
        look(r, 1, 1);
        q = r;
        q.has_pasid = 1'b1;
        q.pasid = r.default_pasid_field;
        look(q, 0, 0);
        share_nopasid_i <= 1'b1;
        look(q, 0, 1);
        share_nopasid_i <= 1'b0;
        q.addr[30] = ~q.addr[30];
        look(q, 1, 1);
        q.pasid = q.pasid + 20'h1;
        look(q, 0, 0);
        q.has_pasid = 1'b0;
        look(q, 0, 0);
        q = r;
        q.pasid = r.default_pasid_field;
        u_host.issue(3'h4, q, tct_isel_s'(5'h04));
        look(r, 0, 0);
        // Context cache: source id is the whole lookup tag
        r = rnd(TCT_CC);
        look(r, 1, 1);
        q = r;
        q.addr = ~r.addr;
        q.did = ~r.did;
        look(q, 0, 1);
        q.sid = ~r.sid;
        look(q, 0, 0);
        u_host.issue(3'h4, r, tct_isel_s'(5'h10));
        look(r, 0, 0);
        // PASID cache, with and without a PASID on the request
        r = rnd(TCT_PC);
        r.scalable = 1'b1;
        r.has_pasid = 1'b1;
        look(r, 1, 1);
        q = r;
        q.pasid = ~r.pasid;
        look(q, 0, 0);
        r.has_pasid = 1'b0;
        look(r, 1, 1);
        q = r;
        q.has_pasid = 1'b1;
        q.pasid = r.default_pasid_field;
        look(q, 0, 1);
        r.default_pasid_field = ~r.default_pasid_field;
        look(r, 0, 0);
        // Paging-structure caches at every level
        for (int i = 0; i < 8; i++)
        begin
            r = rnd(i < 4 ? TCT_FLP : TCT_SLP);
            r.scalable = 1'b1;
            r.has_pasid = 1'b1;
            r.size = tct_size_e'(i % 4);
            lo = low_bit(r.size, 1'b1);
            hi = i < 4 ? 56 : int'(max_guest_addr_width_i);
            look(r, 1, 1);
            q = r;
            q.addr = r.addr ^ ((64'h1 << lo) - 64'h1);
            look(q, 0, 1);
            q.addr[lo] = ~q.addr[lo];
            look(q, 0, lo > hi);
        end
        // Interrupt cache: index is the only tag
        r = rnd(TCT_IRC);
        look(r, 1, 1);
        q = rnd(TCT_IRC);
        q.iidx = r.iidx;
        q.data = r.data;
        look(q, 0, 1);
        q.iidx = ~r.iidx;
        look(q, 0, 0);
        tally_and_finish();
    end
endmodule : testbench
